//--- hdl/emu_pkg.sv
/*
 Constants for the emulator breakpoint and trace block: register offsets,
 control and status field positions, reset values, memory sizes and the
 bit layout of the synchronised target pin vector.
 Assumes a single 40 MHz clock domain.
*/
package emu_pkg;
   // Register offsets on the plain register port
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_BKPT = 4'h1;
   localparam logic [3:0] OFS_STAT = 4'h2;
   localparam logic [3:0] OFS_MASK = 4'h3;
   localparam logic [3:0] OFS_TPTR = 4'h4;
   localparam logic [3:0] OFS_TIDX = 4'h5;
   localparam logic [3:0] OFS_TDATA = 4'h6;
   localparam logic [3:0] OFS_PADDR = 4'h7;
   localparam logic [3:0] OFS_PDATA = 4'h8;
   localparam logic [3:0] OFS_STATE = 4'h9;
   // Control register fields
   localparam int CTL_HOLD = 0;
   localparam int CTL_TRAP = 1;
   localparam int CTL_TREN = 2;
   localparam int CTL_TCONT = 3;
   localparam int CTL_BKEN = 4;
   localparam int CTL_BKQUAL = 5;
   localparam int CTL_BKFETCH = 6;
   localparam int CTL_TFETCH = 7;
   localparam int CTL_FOURPH = 8;
   localparam int CTL_MAPEN = 9;
   localparam int CTL_RESUME = 10;
   localparam logic [15:0] CTRL_RESET = 16'h0100;
   localparam logic [15:0] CTRL_WMASK = 16'h03ff;
   // Status and mask fields
   localparam int ST_W = 4;
   localparam int ST_HALT = 0;
   localparam int ST_BKPT = 1;
   localparam int ST_CLKERR = 2;
   localparam int ST_TFULL = 3;
   // Memories
   localparam int TRACE_DEPTH = 256;
   localparam int PROG_WORDS = 4096;
   localparam logic [7:0] TRACE_LAST = 8'hff;
   localparam logic [2:0] PROG_WIN = 3'h0;
   localparam logic [6:0] TRACE_WIN = 7'h10;
   // Synchronised pin vector layout
   localparam int SYNC_W = 38;
   localparam int P_ADDR = 0;
   localparam int P_DATA = 16;
   localparam int P_MEMEN = 32;
   localparam int P_WE = 33;
   localparam int P_FETCH = 34;
   localparam int P_THOLD = 35;
   localparam int P_PH2 = 36;
   localparam int P_PH4 = 37;
endpackage

//--- hdl/emulator_breakpoint_trace.sv
/*
 Emulator control block: breakpoint comparator, 256-entry address trace,
 8K-byte program memory mapped into the target, host interrupt, hold/trap,
 trace module handshake and clock phase overlap guard.
 Register offsets: control, breakpoint, status (write one to clear), mask,
 trace pointer, trace index, trace data, program address, program data and
 a read-only state word. Trace data and program data accesses step their
 index by one, so software can stream a whole memory.
 Target pins pass a three-stage synchroniser; a memory cycle ends when the
 filtered memory enable falls, and every target-side event (breakpoint,
 trace write, halt) is resolved on that edge.
 Assumes target pins are asynchronous to MCLK and that software owns the
 plain register port with one-cycle strobes.
 Assumes the target keeps address, data and qualifiers steady while the
 memory enable is high and for a few clocks either side of it, so that the
 synchroniser never splits a bus value across two cycles.
 Assumes the host never raises WR and RD in the same cycle.
*/
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module emulator_breakpoint_trace
   import emu_pkg::*;
(
   // Clock and reset
   input wire logic MCLK,
   input wire logic RESET,
   // Register port
   input wire logic [3:0] ADDR,
   input wire logic [15:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [15:0] RDATA,
   output logic IRQ,
   // Target address and data buses
   input wire logic [15:0] TGT_ADDR_I,
   output logic [15:0] TGT_ADDR_O,
   output logic TGT_ADDR_OE,
   input wire logic [15:0] TGT_DATA_I,
   output logic [15:0] TGT_DATA_O,
   output logic TGT_DATA_OE,
   // Target control
   input wire logic TGT_MEMEN,
   input wire logic TGT_WE,
   input wire logic INSTR_FETCH_FLAG,
   output logic TGT_HOLD,
   output logic TGT_TRAP,
   // Clock phases and guard
   input wire logic PH2,
   input wire logic PH4,
   output logic PROC_POWER_OFF,
   output logic CLK_ERROR,
   // Trace module handshake
   input wire logic TRACE_HOLD_REQ,
   output logic TRACE_BKPT,
   output logic TRACE_EOC
);

   typedef struct packed {
      logic [SYNC_W-1:0] s1;
      logic [SYNC_W-1:0] s2;
      logic [SYNC_W-1:0] s3;
      logic [SYNC_W-1:0] filt;
      logic [15:0] ctrl;
      logic [15:0] bkpt;
      logic [ST_W-1:0] stat;
      logic [ST_W-1:0] mask;
      logic [15:0] rdata;
      logic [15:0] dout;
      logic [15:0] aout;
      logic [7:0] wptr;
      logic [7:0] tidx;
      logic [11:0] paddr;
      logic wrapped;
      logic tstop;
      logic halted;
      logic hold;
      logic trap;
      logic irq;
      logic eoc;
      logic bkhit;
      logic pwr_off;
      logic doe;
      logic aoe;
   } state_type;

   // Reset image: control at its reset value, address drivers on
   localparam state_type RST = '{ctrl: CTRL_RESET, aoe: 1'b1, default: '0};

   // Registered state and its next value
   state_type q;
   state_type n;
   logic [SYNC_W-1:0] pins;
   logic [SYNC_W-1:0] filt_d;

   // Memories
   // Trace ring and program store, one write port each
   logic [15:0] trace_mem [TRACE_DEPTH];
   logic [15:0] prog_mem [PROG_WORDS];
   logic trace_we;
   logic [7:0] trace_wa;
   logic [15:0] trace_wd;
   logic prog_we;
   logic [11:0] prog_wa;
   logic [15:0] prog_wd;

   // Combinational helpers
   // Decoded once per cycle, shared by the groups below
   logic mem_start;
   logic mem_end;
   logic qual_ok;
   logic match;
   logic record;
   logic full_stop;
   logic overlap;
   logic resume;
   logic halt_set;
   logic [ST_W-1:0] st_set;
   logic [ST_W-1:0] st_clr;

   // Raw target pins in the synchroniser's bit order
   assign pins = {PH4, PH2, TRACE_HOLD_REQ, INSTR_FETCH_FLAG, TGT_WE, TGT_MEMEN,
                  TGT_DATA_I, TGT_ADDR_I};

   // A change counts once stages two and three agree
   // A glitch shorter than one clock never reaches the logic
   genvar gi;
   generate
      for (gi = 0; gi < SYNC_W; gi++) begin : g_filt
         assign filt_d[gi] = (q.s2[gi] == q.s3[gi]) ? q.s3[gi] : q.filt[gi];
      end
   endgenerate

   // Next-state logic
   always_comb begin
      // Defaults: pulses drop, no memory write, no read answer
      n = q;
      n.s1 = pins;
      n.s2 = q.s1;
      n.s3 = q.s2;
      n.filt = filt_d;
      n.eoc = 1'b0;
      n.bkhit = 1'b0;
      n.rdata = 16'h0000;
      trace_we = 1'b0;
      trace_wa = q.wptr;
      trace_wd = q.filt[P_ADDR +: 16];
      prog_we = 1'b0;
      prog_wa = q.filt[P_ADDR+1 +: 12];
      prog_wd = q.filt[P_DATA +: 16];
      resume = 1'b0;
      st_clr = '0;

      // A cycle starts and ends on edges of the filtered enable
      // memory cycle timing
      mem_start = filt_d[P_MEMEN] & ~q.filt[P_MEMEN];
      mem_end = ~filt_d[P_MEMEN] & q.filt[P_MEMEN];
      n.eoc = mem_end;

      // Unqualified compares accept any memory cycle
      // breakpoint qualification
      if (!q.ctrl[CTL_BKQUAL]) begin
         qual_ok = 1'b1;
      end else if (q.ctrl[CTL_BKFETCH]) begin
         qual_ok = q.filt[P_FETCH];
      end else begin
         qual_ok = q.filt[P_WE] & ~q.filt[P_FETCH];
      end
      match = mem_end & q.ctrl[CTL_BKEN] & ~q.halted & qual_ok
              & (q.filt[P_ADDR +: 16] == q.bkpt);
      n.bkhit = match;

      // Trace module hold pauses recording, never the target
      // trace recording qualifiers
      record = mem_end & q.ctrl[CTL_TREN] & ~q.tstop & ~q.filt[P_THOLD]
               & (~q.ctrl[CTL_TFETCH] | q.filt[P_FETCH]);
      // Last entry written with wrap off: stop after this write
      full_stop = record & ~q.ctrl[CTL_TCONT] & (q.wptr == TRACE_LAST);
      if (record) begin
         trace_we = 1'b1;
         n.wptr = q.wptr + 8'h01;
         if (q.wptr == TRACE_LAST) begin
            n.wrapped = 1'b1;
         end
      end
      if (full_stop) begin
         n.tstop = 1'b1;
      end
      // The breakpoint cycle itself is still recorded
      // continuous mode ends at breakpoint
      if (match && q.ctrl[CTL_TCONT]) begin
         n.tstop = 1'b1;
      end

      // Phases are taken filtered, so a brief overlap is ignored
      // phase overlap, four-phase variant only
      overlap = q.ctrl[CTL_FOURPH] & q.filt[P_PH2] & q.filt[P_PH4];
      if (overlap) begin
         n.pwr_off = 1'b1;
      end

      // Windows decode from the address as the cycle starts
      // target access to mapped memories
      if (mem_start && q.ctrl[CTL_MAPEN] && !filt_d[P_WE]) begin
         if (filt_d[P_ADDR+13 +: 3] == PROG_WIN) begin
            n.doe = 1'b1;
            n.dout = prog_mem[filt_d[P_ADDR+1 +: 12]];
         end else if (filt_d[P_ADDR+9 +: 7] == TRACE_WIN) begin
            n.doe = 1'b1;
            n.dout = trace_mem[filt_d[P_ADDR+1 +: 8]];
         end
      end
      // Release the data bus as the cycle ends
      if (mem_end) begin
         n.doe = 1'b0;
      end
      // Data is the last filtered value seen in the cycle
      // target write into program memory
      if (mem_end && q.ctrl[CTL_MAPEN] && q.filt[P_WE]
          && q.filt[P_ADDR+13 +: 3] == PROG_WIN) begin
         prog_we = 1'b1;
      end

      // Unmapped offsets fall through and are ignored
      // host register writes
      if (WR) begin
         unique case (ADDR)
            OFS_CTRL: begin
               n.ctrl = WDATA & CTRL_WMASK;
               resume = WDATA[CTL_RESUME];
            end
            OFS_BKPT: n.bkpt = WDATA;
            OFS_STAT: st_clr = WDATA[ST_W-1:0];
            OFS_MASK: n.mask = WDATA[ST_W-1:0];
            OFS_TPTR: begin
               n.wptr = 8'h00;
               n.wrapped = 1'b0;
               n.tstop = 1'b0;
            end
            OFS_TIDX: n.tidx = WDATA[7:0];
            OFS_PADDR: n.paddr = WDATA[11:0];
            OFS_PDATA: begin
               prog_we = 1'b1;
               prog_wa = q.paddr;
               prog_wd = WDATA;
               n.paddr = q.paddr + 12'h001;
            end
            default: ;
         endcase
      end

      // Read answer is registered and zero outside its cycle
      // host register reads
      if (RD) begin
         unique case (ADDR)
            OFS_CTRL: n.rdata = q.ctrl;
            OFS_BKPT: n.rdata = q.bkpt;
            OFS_STAT: n.rdata = {12'h000, q.stat};
            OFS_MASK: n.rdata = {12'h000, q.mask};
            OFS_TPTR: n.rdata = {6'h00, q.tstop, q.wrapped, q.wptr};
            OFS_TIDX: n.rdata = {8'h00, q.tidx};
            OFS_TDATA: begin
               n.rdata = trace_mem[q.tidx];
               n.tidx = q.tidx + 8'h01;
            end
            OFS_PADDR: n.rdata = {4'h0, q.paddr};
            OFS_PDATA: begin
               n.rdata = prog_mem[q.paddr];
               n.paddr = q.paddr + 12'h001;
            end
            OFS_STATE: n.rdata = {10'h000, q.pwr_off, q.doe, q.trap, q.hold,
                                  q.tstop, q.halted};
            default: n.rdata = 16'h0000;
         endcase
      end

      // Resume is a write pulse and is never stored
      // halt, a new halt wins over resume
      halt_set = match | full_stop;
      if (resume) begin
         n.halted = 1'b0;
      end
      if (halt_set) begin
         n.halted = 1'b1;
      end

      // Only the first cycle of a halt counts as a halt event
      // sticky event bits, set wins over clear
      st_set = '0;
      st_set[ST_HALT] = halt_set & ~q.halted;
      st_set[ST_BKPT] = match;
      st_set[ST_CLKERR] = overlap;
      st_set[ST_TFULL] = full_stop;
      n.stat = (q.stat & ~st_clr) | st_set;
      // Power stays off while the phases still overlap
      // clearing the error restores power
      if (st_clr[ST_CLKERR] && !overlap) begin
         n.pwr_off = 1'b0;
      end
      // Next status used so the line rises with the bit
      // pending until cleared, masked output
      n.irq = |(n.stat & n.mask);

      // A halt also holds the processor until resumed
      // hold and trap to the processor
      n.hold = n.ctrl[CTL_HOLD] | n.halted;
      n.trap = n.ctrl[CTL_TRAP];
      // Address copy follows the filtered pins
      // address drivers float while processor held
      n.aout = filt_d[P_ADDR +: 16];
      n.aoe = ~n.hold;
   end

   // State register
   // Reset loads the whole image at once
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         q <= RST;
      end else begin
         q <= n;
      end
   end

   // Trace memory write port
   // Ring write at the pointer; a full ring wraps to zero
   always_ff @(posedge MCLK) begin
      if (trace_we) begin
         trace_mem[trace_wa] <= trace_wd;
      end
   end

   // Program memory write port, host has priority
   // Host data replaces a same-cycle target write
   always_ff @(posedge MCLK) begin
      if (prog_we) begin
         prog_mem[prog_wa] <= prog_wd;
      end
   end

   // Outputs straight from the state register
   // Clock error and power removal share one flop
   assign RDATA = q.rdata;
   assign IRQ = q.irq;
   assign TGT_ADDR_O = q.aout;
   assign TGT_ADDR_OE = q.aoe;
   assign TGT_DATA_O = q.dout;
   assign TGT_DATA_OE = q.doe;
   assign TGT_HOLD = q.hold;
   assign TGT_TRAP = q.trap;
   assign PROC_POWER_OFF = q.pwr_off;
   assign CLK_ERROR = q.pwr_off;
   assign TRACE_BKPT = q.bkhit;
   assign TRACE_EOC = q.eoc;

endmodule
`default_nettype wire

//--- test/emu_assertions.sv
/*
 Checker for the emulator block: watches the top module's ports only.
 Assumes a single MCLK domain and a bind placed by the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module emu_checker
   import emu_pkg::*;
(
   // Clock and reset
   input wire logic MCLK,
   input wire logic RESET,
   // Register port
   input wire logic [3:0] ADDR,
   input wire logic [15:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [15:0] RDATA,
   // Target side
   input wire logic TGT_ADDR_OE,
   input wire logic TGT_HOLD,
   input wire logic TGT_TRAP,
   input wire logic PROC_POWER_OFF,
   input wire logic CLK_ERROR,
   input wire logic TRACE_BKPT,
   input wire logic TRACE_EOC
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (RESET);
   read_idle_a: assert property (!$past(RD) |-> RDATA == 16'h0)
      else $error("read data not zero outside a read answer");
   trap_set_a: assert property (WR && ADDR == OFS_CTRL && WDATA[CTL_TRAP] |-> ##1 TGT_TRAP)
      else $error("trap request missing after command");
   trap_clear_a: assert property (WR && ADDR == OFS_CTRL && !WDATA[CTL_TRAP] |-> ##1 !TGT_TRAP)
      else $error("trap request stays after clear");
   hold_set_a: assert property (WR && ADDR == OFS_CTRL && WDATA[CTL_HOLD] |-> ##1 TGT_HOLD)
      else $error("hold request missing after command");
   hold_cause_a: assert property ($rose(TGT_HOLD) |->
      TRACE_EOC || $past(WR))
      else $error("hold rose without cycle end or write");
   addr_release_a: assert property (TGT_HOLD |-> !TGT_ADDR_OE)
      else $error("address driver on while held");
   bkpt_pulse_a: assert property (TRACE_BKPT |=> !TRACE_BKPT)
      else $error("breakpoint indication longer than one cycle");
   eoc_pulse_a: assert property (TRACE_EOC |=> !TRACE_EOC)
      else $error("end of cycle longer than one cycle");
   bkpt_at_end_a: assert property (TRACE_BKPT |-> TRACE_EOC)
      else $error("breakpoint indication away from cycle end");
   err_power_a: assert property (CLK_ERROR == PROC_POWER_OFF)
      else $error("clock error and power off differ");
   power_sticky_a: assert property (PROC_POWER_OFF && !WR |=> PROC_POWER_OFF)
      else $error("power off dropped without a write");
endmodule
`default_nettype wire

//--- test/emulator_breakpoint_trace_bench.sv
/*
 Bench for the emulator block: register tasks, target model, checks.
 Assumes checker and target model are compiled before this file.
*/
`timescale 1ns/1ps
`default_nettype none
module emulator_breakpoint_trace_bench;
   import emu_pkg::*;
   logic mclk, reset, wr_en, rd_en, ph2, ph4, thold;
   logic [3:0] addr;
   logic [15:0] wdata, rdata, ta_i, ta_o, td_i, td_o, got, b, d, m, e;
   logic ta_oe, td_oe, memen, we, fetch, irq, hold, trap, pwr, cerr, tbk, teoc;
   logic [11:0] w;
   logic [15:0] t [4];
   logic [19:0] mode [5] = '{20'hc0110, 20'h00170, 20'he0170, 20'h20130, 20'hd0130};
   int n_fail, n_tests, i;
   // Design and target model
   emulator_breakpoint_trace u_emulator_breakpoint_trace (.MCLK(mclk), .RESET(reset),
      .ADDR(addr), .WDATA(wdata), .WR(wr_en), .RD(rd_en), .RDATA(rdata), .IRQ(irq),
      .TGT_ADDR_I(ta_i), .TGT_ADDR_O(ta_o), .TGT_ADDR_OE(ta_oe), .TGT_DATA_I(td_i),
      .TGT_DATA_O(td_o), .TGT_DATA_OE(td_oe), .TGT_MEMEN(memen), .TGT_WE(we),
      .INSTR_FETCH_FLAG(fetch), .TGT_HOLD(hold), .TGT_TRAP(trap), .PH2(ph2), .PH4(ph4),
      .PROC_POWER_OFF(pwr), .CLK_ERROR(cerr), .TRACE_HOLD_REQ(thold), .TRACE_BKPT(tbk),
      .TRACE_EOC(teoc));
   target_model u_target_model (.clk(mclk), .hold(hold), .addr(ta_i), .data(td_i),
      .memen(memen), .we(we), .fetch(fetch), .rdata(td_o), .rdata_oe(td_oe), .got(got));
   // Word address to program window address
   function automatic logic [15:0] prog_addr(input logic [11:0] wa);
      return {PROG_WIN, wa, 1'b0};
   endfunction
   task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] g);
      n_tests++;
      if (g !== ex) begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", nm, ex, g);
      end
   endtask
   task automatic reg_wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge mclk);
      addr <= a;
      wdata <= v;
      wr_en <= 1'b1;
      @(posedge mclk);
      wr_en <= 1'b0;
   endtask
   task automatic reg_rd_chk(input logic [3:0] a, input logic [15:0] ex, input string nm);
      @(posedge mclk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge mclk);
      rd_en <= 1'b0;
      #1;
      chk(nm, ex, rdata);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Clock
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   // Watchdog
   initial begin
      repeat (20000) @(posedge mclk);
      n_fail++;
      end_sim;
   end
   // Main sequence
   initial begin
      {reset, wr_en, rd_en, ph2, ph4, thold, addr, wdata} = {1'b1, 25'h0};
      n_fail = 0;
      n_tests = 0;
      void'($urandom(86));
      repeat (3) @(posedge mclk);
      reset <= 1'b0;
      reg_rd_chk(OFS_CTRL, CTRL_RESET, "control");
      reg_rd_chk(4'hf, 16'h0, "unmapped");
      $display("test reset done");
      reg_wr(OFS_CTRL, 16'h0103);
      settle(2);
      chk("hold", 1, hold);
      chk("trap", 1, trap);
      chk("address enable", 0, ta_oe);
      reg_wr(OFS_CTRL, CTRL_RESET);
      settle(2);
      chk("trap", 0, trap);
      $display("test hold done");
      // Breakpoint modes with a random mask
      b = 16'($urandom) & 16'hfffe;
      reg_wr(OFS_BKPT, b);
      for (i = 0; i < 5; i++) begin
         m = 16'($urandom % 4);
         e = {14'h0, mode[i][19:18]};
         reg_wr(OFS_MASK, m);
         reg_wr(OFS_CTRL, mode[i][15:0]);
         u_target_model.run(b, mode[i][16], mode[i][17], 6 + int'($urandom % 4));
         reg_rd_chk(OFS_STAT, e, "status");
         reg_wr(OFS_CTRL, 16'h0500);
         settle(2);
         chk("irq", |(e & m), irq);
         reg_wr(OFS_STAT, 16'h0003);
         settle(2);
         chk("irq", 0, irq);
      end
      $display("test breakpoint done");
      reg_wr(OFS_CTRL, 16'h0104);
      reg_wr(OFS_TPTR, 16'h0);
      for (i = 0; i < TRACE_DEPTH; i++) begin
         if (i == TRACE_DEPTH - 1) chk("hold", 0, hold);
         u_target_model.run(16'($urandom) | 16'h0001, 1'b0, 1'($urandom), 6);
      end
      reg_rd_chk(OFS_STAT, 16'h0009, "status");
      chk("hold", 1, hold);
      reg_wr(OFS_CTRL, 16'h0500);
      reg_wr(OFS_STAT, 16'h000f);
      // Continuous trace, fetch only, paused by the trace module hold
      reg_wr(OFS_CTRL, 16'h019c);
      reg_wr(OFS_TPTR, 16'h0);
      for (i = 0; i < 4; i++) begin
         t[i] = 16'($urandom) | 16'h0001;
         thold <= (i == 3);
         u_target_model.run(t[i], 1'b0, i != 1, 6);
      end
      thold <= 1'b0;
      settle(1);
      chk("address out", ~t[3], ta_o);
      u_target_model.run(b, 1'b0, 1'b1, 6);
      reg_rd_chk(OFS_TPTR, 16'h0203, "trace pointer");
      reg_wr(OFS_TIDX, 16'h0);
      reg_rd_chk(OFS_TDATA, t[0], "trace entry");
      reg_rd_chk(OFS_TDATA, t[2], "trace entry");
      reg_rd_chk(OFS_TDATA, b, "trace entry");
      chk("hold", 1, hold);
      reg_wr(OFS_CTRL, 16'h0500);
      reg_wr(OFS_STAT, 16'h000f);
      $display("test trace done");
      w = 12'($urandom);
      d = 16'($urandom);
      reg_wr(OFS_PADDR, {4'h0, w});
      reg_wr(OFS_PDATA, d);
      reg_wr(OFS_PADDR, {4'h0, w});
      reg_rd_chk(OFS_PDATA, d, "program data");
      reg_wr(OFS_CTRL, 16'h0300);
      u_target_model.run(prog_addr(w), 1'b0, 1'b0, 8);
      chk("mapped read", d, got);
      $display("test mapping done");
      reg_wr(OFS_CTRL, 16'h0000);
      ph2 <= 1'b1;
      ph4 <= 1'b1;
      settle(8);
      chk("clock error", 0, cerr);
      reg_wr(OFS_CTRL, CTRL_RESET);
      settle(8);
      chk("clock error", 1, cerr);
      chk("power off", 1, pwr);
      reg_rd_chk(OFS_STAT, 16'h0004, "status");
      $display("test overlap done");
      end_sim;
   end
endmodule
bind emulator_breakpoint_trace emu_checker u_emu_checker (.MCLK(MCLK), .RESET(RESET),
   .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .TGT_ADDR_OE(TGT_ADDR_OE),
   .TGT_HOLD(TGT_HOLD), .TGT_TRAP(TGT_TRAP), .PROC_POWER_OFF(PROC_POWER_OFF),
   .CLK_ERROR(CLK_ERROR), .TRACE_BKPT(TRACE_BKPT), .TRACE_EOC(TRACE_EOC));
`default_nettype wire

//--- test/target_model.sv
/*
 Target processor bus model: runs one memory cycle per call.
 Assumes the bench calls run from its main sequence only.
*/
`timescale 1ns/1ps
`default_nettype none
module target_model (
   // Clock and hold
   input wire logic clk,
   input wire logic hold,
   // Processor bus pins
   output logic [15:0] addr,
   output logic [15:0] data,
   output logic memen,
   output logic we,
   output logic fetch,
   // Mapped read answer
   input wire logic [15:0] rdata,
   input wire logic rdata_oe,
   output logic [15:0] got
);
   // Idle bus at time zero
   initial begin
      addr = 16'h0;
      data = 16'h0;
      memen = 1'b0;
      we = 1'b0;
      fetch = 1'b0;
      got = 16'h0;
   end
   // One memory cycle, len clocks active and len idle
   task automatic run(input logic [15:0] a, input logic w, input logic f, input int len);
      int n;
      n = 0;
      while (hold === 1'b1 && n < 50) begin
         @(posedge clk);
         n++;
      end
      @(posedge clk);
      addr <= a;
      we <= w;
      fetch <= f;
      data <= 16'($urandom);
      memen <= 1'b1;
      repeat (len) @(posedge clk);
      got <= (rdata_oe === 1'b1) ? rdata : 16'hxxxx;
      memen <= 1'b0;
      we <= 1'b0;
      fetch <= 1'b0;
      addr <= ~a;
      data <= ~data;
      repeat (len) @(posedge clk);
   endtask
endmodule
`default_nettype wire
